// ==== bench/nvm_device_model.sv ====
// Behavioural model of the EEPROM/Flash device behind the host controller
`timescale 1ns/10ps
module nvm_device_model
   import nvm_ctrl_pkg::*;
   #(parameter int ERWIN = 30)
   (input  wire logic              sys_clk,
    input  wire logic [ADDR_W-1:0] busAddr,
    input  wire logic [DATA_W-1:0] busDataOut,
    input  wire logic              wrStrobe_n,
    input  wire logic              rdStrobe_n,
    input  wire logic              eeSel,
    input  wire logic              flSel,
    input  wire logic [15:0]       busyLen,
    output logic      [DATA_W-1:0] busDataIn);
   localparam logic [14:0] SA [0:5] = '{SEQ_ADDR_A, SEQ_ADDR_B, SEQ_ADDR_A,
                                        SEQ_ADDR_A, SEQ_ADDR_B, SEQ_ADDR_A};
   localparam logic [7:0] SD [0:4] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
   logic [7:0]  ee [0:32767];
   logic [7:0]  fl [0:32767];
   logic [7:0]  otp [0:63];
   logic [14:0] hA [0:5];
   logic [7:0]  hD [0:5];
   logic [15:0] busy = 16'h0;
   logic [15:0] erwin = 16'h0;
   logic        lockMode = 1'b0;
   logic        unlockOk = 1'b0;
   logic        otpArm = 1'b0;
   logic        progArm = 1'b0;
   logic        fail = 1'b0;
   logic        erasing = 1'b0;
   logic        pend7 = 1'b0;
   logic        toggle = 1'b0;
   logic        prevWr = 1'b1;
   logic        prevRd = 1'b1;
   logic [7:0]  outByte = 8'h00;

   initial begin
      for (int i = 0; i < 32768; i++) begin
         ee[i] = 8'hFF;
         fl[i] = 8'h00;
      end
      for (int i = 0; i < 64; i++) otp[i] = 8'hFF;
      for (int i = 0; i < 6; i++) begin
         hA[i] = 15'h0;
         hD[i] = 8'h00;
      end
   end

   function automatic bit tail(input int n, input logic [7:0] last);
      tail = hD[5] == last && (hA[5] == SA[5] || last == SEQ_D_ERASE);
      for (int i = 6 - n; i < 5; i++)
         tail &= hA[i] == SA[i] && hD[i] == SD[i];
   endfunction

   // Released bus shows the inverse so stale data never passes
   assign busDataIn = rdStrobe_n ? ~outByte : outByte;

   always @(posedge sys_clk) begin
      logic [14:0] a;
      logic [7:0]  d;
      a = busAddr;
      d = busDataOut;
      if (busy != 16'h0 && !fail) begin
         busy <= busy - 16'h1;
         if (busy == 16'h1) begin
            unlockOk <= 1'b0;
            otpArm <= 1'b0;
         end
      end
      if (erwin != 16'h0) erwin <= erwin - 16'h1;
      if (!prevWr && wrStrobe_n && (eeSel || flSel)) begin
         for (int i = 0; i < 5; i++) begin
            hA[i] = hA[i+1];
            hD[i] = hD[i+1];
         end
         hA[5] = a;
         hD[5] = d;
         if (flSel) begin
            if (progArm) begin
               if ((d & ~fl[a]) != 8'h00) fail <= 1'b1;
               fl[a] <= fl[a] & d;
               pend7 <= d[7];
               erasing <= 1'b0;
               progArm <= 1'b0;
               busy <= busyLen;
            end else if (tail(3, SEQ_D_PROG)) begin
               progArm <= 1'b1;
            end else if (tail(6, SEQ_D_ERASE)) begin
               for (int i = 0; i < 4096; i++) fl[{a[14:12], 12'(i)}] <= 8'hFF;
               erasing <= 1'b1;
               erwin <= 16'(ERWIN);
               busy <= busyLen;
            end else if (d == SEQ_D_RESET) begin
               fail <= 1'b0;
               busy <= 16'h0;
            end
         end else if (tail(6, SEQ_D_UNLOCK)) begin
            lockMode <= 1'b0;
            busy <= busyLen;
         end else if (tail(3, SEQ_D_LOCK)) begin
            lockMode <= 1'b1;
            unlockOk <= 1'b1;
            busy <= busyLen;
         end else if (tail(3, SEQ_D_OTP)) begin
            otpArm <= !lockMode;
         end else if (otpArm) begin
            if (!a[6] && otp[a[5:0]] == 8'hFF) otp[a[5:0]] <= d;
            busy <= busyLen;
         end else if (!lockMode || unlockOk) begin
            ee[a] <= d;
            pend7 <= d[7];
            erasing <= 1'b0;
            busy <= busyLen;
         end
      end
      if (prevRd && !rdStrobe_n) begin
         if (busy != 16'h0) begin
            toggle <= !toggle;
            outByte <= {erasing ? 1'b0 : !pend7, !toggle, fail, 1'b0,
                        erwin == 16'h0, 3'b000};
         end else begin
            outByte <= flSel ? fl[a] : ee[a];
         end
      end
      prevWr <= wrStrobe_n;
      prevRd <= rdStrobe_n;
   end
endmodule

// ==== bench/tb_nvm_write_status_sequencer.sv ====
// Self-checking bench for the write/status sequencer and device model
`timescale 1ns/10ps
module tb_nvm_write_status_sequencer
   import nvm_ctrl_pkg::*;
   ;
   logic              sys_clk;
   logic              rst = 1'b1;
   logic              loadEn = 1'b0;
   logic [PAGE_W-1:0] loadIdx = '0;
   logic [DATA_W-1:0] loadData = '0;
   logic              cmdValid = 1'b0;
   logic [2:0]        cmdCode = '0;
   logic [ADDR_W-1:0] cmdAddr = '0;
   logic [DATA_W-1:0] cmdData = '0;
   logic [PAGE_W:0]   cmdCount = '0;
   logic [15:0]       busyLen = 16'd80;
   logic              cmdReady, done, failed, busDataOe_n;
   logic              wrStrobe_n, rdStrobe_n, eeSel, flSel;
   logic [DATA_W-1:0] lastStatus, busDataOut, busDataIn;
   logic [ADDR_W-1:0] busAddr;
   int                mismatches = 0;
   int                compares = 0;

   nvm_write_status_sequencer #(.INACT_CYC(50), .POLL_LIMIT(200)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .loadEn(loadEn), .loadIdx(loadIdx),
      .loadData(loadData), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdCount(cmdCount),
      .cmdReady(cmdReady), .done(done), .failed(failed),
      .lastStatus(lastStatus), .busAddr(busAddr), .busDataOut(busDataOut),
      .busDataIn(busDataIn), .busDataOe_n(busDataOe_n),
      .wrStrobe_n(wrStrobe_n), .rdStrobe_n(rdStrobe_n), .eeSel(eeSel),
      .flSel(flSel));

   nvm_device_model i_dev (
      .sys_clk(sys_clk), .busAddr(busAddr), .busDataOut(busDataOut),
      .wrStrobe_n(wrStrobe_n), .rdStrobe_n(rdStrobe_n), .eeSel(eeSel),
      .flSel(flSel), .busyLen(busyLen), .busDataIn(busDataIn));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic load(input logic [5:0] idx, input logic [7:0] data);
      @(posedge sys_clk);
      loadEn <= 1'b1;
      loadIdx <= idx;
      loadData <= data;
      @(posedge sys_clk);
      loadEn <= 1'b0;
   endtask

   // Issue one command and wait, bounded, for its done pulse
   task automatic run(input logic [2:0] code, input logic [14:0] addr,
                      input logic [7:0] data, input logic [6:0] count);
      int n;
      n = 0;
      @(posedge sys_clk);
      while (cmdReady !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100) mismatches++;
      cmdValid <= 1'b1;
      cmdCode <= code;
      cmdAddr <= addr;
      cmdData <= data;
      cmdCount <= count;
      @(posedge sys_clk);
      cmdValid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 20000) mismatches++;
   endtask

   task automatic t_reset;
      check({7'h0, cmdReady}, 8'h01);
      check({7'h0, wrStrobe_n}, 8'h01);
      check({6'h0, eeSel, flSel}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_page;
      for (int i = 63; i >= 0; i--) load(6'(i), 8'(i) ^ 8'h3C);
      run(CMD_EE_WRITE, 15'h1040, 8'h00, 7'd64);
      check({7'h0, failed}, 8'h00);
      for (int i = 0; i < 64; i++)
         check(i_dev.ee[15'h1040 + 15'(i)], 8'(i) ^ 8'h3C);
      busyLen <= 16'd300;
      load(6'h00, 8'hC3);
      run(CMD_EE_WRITE, 15'h2000, 8'h00, 7'd1);
      check(i_dev.ee[15'h2000], 8'hC3);
      check({7'h0, failed}, 8'h00);
      busyLen <= 16'd80;
      $display("test page done");
   endtask

   task automatic t_lock;
      load(6'h00, 8'h11);
      run(CMD_LOCK_ON, 15'h3000, 8'h00, 7'd1);
      check({7'h0, i_dev.lockMode}, 8'h01);
      check(i_dev.ee[15'h3000], 8'h11);
      load(6'h00, 8'h22);
      run(CMD_EE_WRITE, 15'h3000, 8'h00, 7'd1);
      check(i_dev.ee[15'h3000], 8'h11);
      run(CMD_OTP, 15'h0000, 8'h00, 7'd1);
      check(i_dev.otp[0], 8'hFF);
      run(CMD_LOCK_OFF, 15'h0000, 8'h00, 7'd0);
      check({7'h0, i_dev.lockMode}, 8'h00);
      check({7'h0, failed}, 8'h00);
      run(CMD_OTP, 15'h0040, 8'h00, 7'd1);
      check(i_dev.otp[0], 8'h22);
      $display("test lock done");
   endtask

   task automatic t_flash;
      run(CMD_FL_ERASE, 15'h4123, 8'h00, 7'd0);
      check(i_dev.fl[15'h4000], 8'hFF);
      check(i_dev.fl[15'h4FFF], 8'hFF);
      check(i_dev.fl[15'h5000], 8'h00);
      check({7'h0, failed}, 8'h00);
      run(CMD_FL_PROG, 15'h4123, 8'h5A, 7'd0);
      check(i_dev.fl[15'h4123], 8'h5A);
      check({7'h0, failed}, 8'h00);
      run(CMD_FL_PROG, 15'h4123, 8'hFF, 7'd0);
      check({7'h0, failed}, 8'h01);
      check({7'h0, lastStatus[BIT_FAIL]}, 8'h01);
      run(CMD_FL_RESET, 15'h4000, 8'h00, 7'd0);
      check({7'h0, i_dev.fail}, 8'h00);
      $display("test flash done");
   endtask

   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t_reset();
      t_page();
      t_lock();
      t_flash();
      tally_and_finish();
   end
endmodule

// ==== rtl/nvm_ctrl_pkg.sv ====
// Constants shared by the nonvolatile memory write/status controller
package nvm_ctrl_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int PAGE_W = 6;
   localparam int PAGE_BYTES = 64;
   localparam int CLK_PERIOD_NS = 4;
   // Device inactivity window after the last EEPROM write
   localparam int EE_INACT_US = 120;
   localparam int EE_INACT_CYC =
      (EE_INACT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Sector-erase gathering window, 100 us plus 20 percent
   localparam int ERASE_WIN_US = 120;
   localparam int ERASE_WIN_CYC =
      (ERASE_WIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POLL_LIMIT_DEF = 2500000;
   // Bus cycle widths in clocks
   localparam logic [3:0] WR_PULSE_CYC = 4'h2;
   localparam logic [3:0] RD_PULSE_CYC = 4'h3;
   // User commands
   localparam logic [2:0] CMD_EE_WRITE = 3'h0;
   localparam logic [2:0] CMD_LOCK_ON  = 3'h1;
   localparam logic [2:0] CMD_LOCK_OFF = 3'h2;
   localparam logic [2:0] CMD_OTP      = 3'h3;
   localparam logic [2:0] CMD_FL_PROG  = 3'h4;
   localparam logic [2:0] CMD_FL_ERASE = 3'h5;
   localparam logic [2:0] CMD_FL_RESET = 3'h6;
   // Command-sequence addresses and data bytes
   localparam logic [ADDR_W-1:0] SEQ_ADDR_A = 15'h0555;
   localparam logic [ADDR_W-1:0] SEQ_ADDR_B = 15'h0AAA;
   localparam logic [DATA_W-1:0] SEQ_D_FIRST  = 8'hAA;
   localparam logic [DATA_W-1:0] SEQ_D_SECOND = 8'h55;
   localparam logic [DATA_W-1:0] SEQ_D_LOCK   = 8'hA0;
   localparam logic [DATA_W-1:0] SEQ_D_SETUP  = 8'h80;
   localparam logic [DATA_W-1:0] SEQ_D_UNLOCK = 8'h20;
   localparam logic [DATA_W-1:0] SEQ_D_OTP    = 8'hB8;
   localparam logic [DATA_W-1:0] SEQ_D_PROG   = 8'hA0;
   localparam logic [DATA_W-1:0] SEQ_D_ERASE  = 8'h30;
   localparam logic [DATA_W-1:0] SEQ_D_RESET  = 8'hF0;
   // Status byte bit positions, then address bit positions (OTP_ZERO_BIT, PAGE_LSB)
   localparam int BIT_POLL   = 7;
   localparam int BIT_TOGGLE = 6;
   localparam int BIT_FAIL   = 5;
   localparam int BIT_ERWIN  = 3;
   localparam int OTP_ZERO_BIT = 6;
   localparam int PAGE_LSB = 6;

   // Number of command writes ahead of the data phase
   function automatic logic [2:0] prefixLen(input logic [2:0] cmd);
      unique case (cmd)
         CMD_LOCK_ON, CMD_OTP, CMD_FL_PROG: prefixLen = 3'h3;
         CMD_LOCK_OFF, CMD_FL_ERASE:        prefixLen = 3'h6;
         CMD_FL_RESET:                      prefixLen = 3'h1;
         default:                           prefixLen = 3'h0;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] seqAddr(input logic [2:0] st);
      seqAddr = (st == 3'h1 || st == 3'h4) ? SEQ_ADDR_B : SEQ_ADDR_A;
   endfunction

   function automatic logic [DATA_W-1:0] seqData(input logic [2:0] cmd,
                                                 input logic [2:0] st);
      unique case (st)
         3'h0, 3'h3: seqData = SEQ_D_FIRST;
         3'h1, 3'h4: seqData = SEQ_D_SECOND;
         3'h2: begin
            unique case (cmd)
               CMD_LOCK_ON:  seqData = SEQ_D_LOCK;
               CMD_OTP:      seqData = SEQ_D_OTP;
               CMD_FL_PROG:  seqData = SEQ_D_PROG;
               default:      seqData = SEQ_D_SETUP;
            endcase
         end
         default: seqData = (cmd == CMD_FL_ERASE) ? SEQ_D_ERASE
                                                  : SEQ_D_UNLOCK;
      endcase
   endfunction
endpackage

// ==== rtl/nvm_write_status_sequencer.sv ====
// Host controller driving EEPROM/Flash writes and completion polling
// Contract
// [R01] Device holds erase window flag low ~100us after sector erase.
// [R02] EEPROM write starts when EEPROM select and write strobe coincide.
// [R03] Device stores EEPROM data after 120us without further writes.
// [R04] Device erases EEPROM internally; host never issues EEPROM erase.
// [R05] Device collects up to 64 page bytes before one storage.
// [R06] Host keeps A14..A6 fixed, under 120us between page writes.
// [R07] Page bytes may come in any order, A5..A0 pick slot.
// [R08] Page storage starts 120us after last write; status as byte.
// [R09] Locked mode stores EEPROM data only after unlock sequence.
// [R10] Lock enable is three fixed writes; locked writes repeat it.
// [R11] Lock disable is six fixed writes; only full sequence counts.
// [R12] Lock setting is nonvolatile across power cycles.
// [R13] During lock commands ready/busy low, toggle flag reports progress.
// [R14] Command writes hit different pages within 120us spacing.
// [R15] One-time row: three writes then data, A6 zero, A5..A0 byte.
// [R16] Device rejects one-time row writes while locked.
// [R17] Flash erases by sector or array; program only clears bits.
// [R18] Polling flag shows complement of bit 7 while programming.
// [R19] Failure flag set on timeout or programming a zero to one.
// [R20] During erase polling flag reads 0; failure flag means timeout.
// [R21] Toggling flag inverts each read until operation completes.
// [R22] On failure flag, host rereads toggle flag before declaring failure.
// [R23] Flags valid from fourth program pulse, sixth erase pulse.
// [R24] Failure flag clears only on reset command.
// [R25] Busy memory returns status byte instead of array data.
`timescale 1ns/10ps
module nvm_write_status_sequencer
   import nvm_ctrl_pkg::*;
   #(parameter int INACT_CYC  = EE_INACT_CYC,
     parameter int POLL_LIMIT = POLL_LIMIT_DEF)
   (input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              loadEn,
    input  wire logic [PAGE_W-1:0] loadIdx,
    input  wire logic [DATA_W-1:0] loadData,
    input  wire logic              cmdValid,
    input  wire logic [2:0]        cmdCode,
    input  wire logic [ADDR_W-1:0] cmdAddr,
    input  wire logic [DATA_W-1:0] cmdData,
    input  wire logic [PAGE_W:0]   cmdCount,
    output logic                   cmdReady,
    output logic                   done,
    output logic                   failed,
    output logic [DATA_W-1:0]      lastStatus,
    output logic [ADDR_W-1:0]      busAddr,
    output logic [DATA_W-1:0]      busDataOut,
    input  wire logic [DATA_W-1:0] busDataIn,
    output logic                   busDataOe_n,
    output logic                   wrStrobe_n,
    output logic                   rdStrobe_n,
    output logic                   eeSel,
    output logic                   flSel);

   initial begin
      if (INACT_CYC < 4 || POLL_LIMIT < 4)
         $error("nvm_write_status_sequencer: counts too small");
   end

   typedef enum logic [7:0] {
      S_IDLE   = 8'b0000_0001,
      S_FETCH  = 8'b0000_0010,
      S_SETUP  = 8'b0000_0100,
      S_PULSE  = 8'b0000_1000,
      S_HOLD   = 8'b0001_0000,
      S_SETTLE = 8'b0010_0000,
      S_READ   = 8'b0100_0000,
      S_DONE   = 8'b1000_0000
   } state_t;

   state_t            state;
   logic [2:0]        cmd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   logic [PAGE_W:0]   count;
   logic [PAGE_W:0]   step;
   logic [3:0]        phase;
   logic [31:0]       waitCnt;
   logic [31:0]       pollCnt;
   logic              havePrev;
   logic              recheck;
   logic [DATA_W-1:0] prev;
   logic [DATA_W-1:0] bufData;
   logic [PAGE_W:0]   pre;
   logic [PAGE_W:0]   total;
   logic              inData;
   logic              eeKind;
   logic [PAGE_W-1:0] slot;
   logic              sampleNow;
   logic [DATA_W-1:0] smp;
   logic              same;
   logic              finish;
   logic              fail;

   assign pre    = {{(PAGE_W-2){1'b0}}, prefixLen(cmd)};
   assign inData = (step >= pre);
   assign eeKind = (cmd != CMD_FL_PROG && cmd != CMD_FL_ERASE
                    && cmd != CMD_FL_RESET);
   assign slot   = PAGE_W'(step - pre);
   assign total  = pre + count;

   page_store #(.WIDTH(DATA_W), .DEPTH(PAGE_BYTES), .IDX_W(PAGE_W))
      staging (.sys_clk(sys_clk),
               .wrEn   (loadEn && state == S_IDLE),
               .wrIdx  (loadIdx),
               .wrData (loadData),
               .rdIdx  (slot),
               .rdData (bufData));

   // Command capture and sequencing
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         cmd   <= CMD_EE_WRITE;
         addr  <= '0;
         data  <= '0;
         count <= '0;
         step  <= '0;
         phase <= '0;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (cmdValid) begin
                  cmd   <= cmdCode;
                  addr  <= cmdAddr;
                  data  <= cmdData;
                  step  <= '0;
                  // Data phase length per command kind
                  if (cmdCode == CMD_FL_PROG)
                     count <= (PAGE_W+1)'(1);
                  else if (cmdCode == CMD_LOCK_OFF ||
                           cmdCode == CMD_FL_ERASE ||
                           cmdCode == CMD_FL_RESET)
                     count <= '0;
                  else
                     count <= cmdCount;
                  state <= S_FETCH;
               end
            end
            S_FETCH: state <= S_SETUP;
            S_SETUP: begin
               phase <= '0;
               state <= S_PULSE;
            end
            S_PULSE: begin
               phase <= phase + 4'h1;
               if (phase == WR_PULSE_CYC - 4'h1)
                  state <= S_HOLD;
            end
            S_HOLD: begin
               step <= step + (PAGE_W+1)'(1);
               if (step + (PAGE_W+1)'(1) < total)
                  state <= S_FETCH;
               else if (cmd == CMD_FL_RESET)
                  state <= S_DONE;
               else
                  state <= S_SETTLE;
            end
            S_SETTLE: begin
               phase <= '0;
               if (waitCnt == '0)
                  state <= S_READ;
            end
            S_READ: begin
               phase <= phase + 4'h1;
               if (phase == RD_PULSE_CYC - 4'h1) begin
                  phase <= '0;
                  if (finish)
                     state <= S_DONE;
                  else
                     state <= S_SETTLE;
               end
            end
            S_DONE:  state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // Wait timer: storage window for EEPROM kinds, one cycle for flash before the first poll
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         waitCnt <= '0;
      // [R08] storage wait
      else if (state == S_HOLD)
         waitCnt <= eeKind ? 32'(INACT_CYC) : 32'd1;
      else if (state == S_SETTLE && waitCnt != '0)
         waitCnt <= waitCnt - 32'd1;
   end

   // Toggle-flag poll decision
   assign sampleNow = (state == S_READ) && (phase == RD_PULSE_CYC - 4'h1);
   assign smp  = busDataIn;
   assign same = havePrev && (smp[BIT_TOGGLE] == prev[BIT_TOGGLE]);
   // [R22] confirm before failing
   assign fail = (havePrev && !same && recheck) ||
                 (pollCnt >= 32'(POLL_LIMIT));
   assign finish = same || fail;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         havePrev <= 1'b0;
         recheck  <= 1'b0;
         prev     <= '0;
         pollCnt  <= '0;
      end else if (state == S_IDLE) begin
         havePrev <= 1'b0;
         recheck  <= 1'b0;
         pollCnt  <= '0;
      end else if (sampleNow) begin
         // [R21] track toggling
         prev     <= smp;
         havePrev <= 1'b1;
         pollCnt  <= pollCnt + 32'd1;
         // [R22] failure flag seen
         if (havePrev && !same && smp[BIT_FAIL] && !eeKind)
            recheck <= 1'b1;
      end
   end

   // Pin drive
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busAddr     <= '0;
         busDataOut  <= '0;
         busDataOe_n <= 1'b1;
         wrStrobe_n  <= 1'b1;
         rdStrobe_n  <= 1'b1;
         eeSel       <= 1'b0;
         flSel       <= 1'b0;
      end else begin
         wrStrobe_n <= !(state == S_SETUP ||
                         (state == S_PULSE && phase != WR_PULSE_CYC-4'h1));
         rdStrobe_n <= !((state == S_SETTLE && waitCnt == '0) ||
                         (state == S_READ && phase != RD_PULSE_CYC-4'h1));
         if (state == S_FETCH) begin
            busDataOe_n <= 1'b0;
            // [R02] select with strobe
            eeSel <= eeKind;
            flSel <= !eeKind;
            if (!inData) begin
               // [R10] [R11] [R14] command prefix writes
               busAddr    <= (cmd == CMD_FL_RESET) ? addr
                           : (cmd == CMD_FL_ERASE && step == pre - 1'b1)
                           ? addr : seqAddr(step[2:0]);
               busDataOut <= (cmd == CMD_FL_RESET) ? SEQ_D_RESET
                           : seqData(cmd, step[2:0]);
            end else if (eeKind) begin
               // [R06] [R07] fixed page, slot from low bits
               busAddr    <= {addr[ADDR_W-1:PAGE_LSB], slot};
               // [R15] row address bit forced low
               if (cmd == CMD_OTP)
                  busAddr[OTP_ZERO_BIT] <= 1'b0;
            end else begin
               busAddr    <= addr;
               busDataOut <= data;
            end
         end else if (state == S_SETUP) begin
            // Staging data is valid one cycle after the slot moves
            if (inData && eeKind)
               busDataOut <= bufData;
         end else if (state == S_SETTLE || state == S_DONE) begin
            busDataOe_n <= 1'b1;
            // Poll reads stay on the last written location
            eeSel <= eeKind;
            flSel <= !eeKind;
         end else if (state == S_IDLE) begin
            busDataOe_n <= 1'b1;
            eeSel <= 1'b0;
            flSel <= 1'b0;
         end
      end
   end

   // Results
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmdReady   <= 1'b0;
         done       <= 1'b0;
         failed     <= 1'b0;
         lastStatus <= '0;
      end else begin
         cmdReady <= (state == S_IDLE) && !cmdValid;
         done     <= (state == S_READ && sampleNow && finish) ||
                     (state == S_HOLD && cmd == CMD_FL_RESET &&
                      step + (PAGE_W+1)'(1) >= total);
         if (state == S_IDLE && cmdValid)
            failed <= 1'b0;
         else if (sampleNow && fail)
            failed <= 1'b1;
         if (sampleNow)
            lastStatus <= smp;
      end
   end

   // Checking helpers
   logic [7:0]        pulses;
   logic [31:0]       gap;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pulses <= '0;
         gap    <= '0;
      end else if (state == S_IDLE) begin
         pulses <= '0;
         gap    <= '0;
      end else begin
         pulses <= pulses + 8'(wrStrobe_n && state == S_SETUP);
         gap    <= (state == S_SETUP) ? 32'd0 : gap + 32'd1;
      end
   end

   sequence sWriteGo;
      state == S_SETUP ##1 state == S_PULSE;
   endsequence
   sequence sStrobeLow;
      !wrStrobe_n [*2];
   endsequence

   a_pulse_shape: assert property (@(posedge sys_clk) disable iff (rst) // [R02]
      sWriteGo |-> sStrobeLow ##1 wrStrobe_n)
      else $error("write strobe width wrong");
   a_prefix_bytes: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
      $fell(wrStrobe_n) && !inData && cmd != CMD_FL_RESET
      && !(cmd == CMD_FL_ERASE && step == pre - 1'b1)
      |-> busAddr == seqAddr(step[2:0])
          && busDataOut == seqData(cmd, step[2:0]) && !busDataOe_n)
      else $error("command prefix byte wrong");
   a_disable_six: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
      $rose(state == S_SETTLE) && cmd == CMD_LOCK_OFF |-> pulses == 8'd6)
      else $error("unlock sequence not six writes");
   a_page_fixed: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
      $fell(wrStrobe_n) && inData && eeKind
      |-> busAddr[ADDR_W-1:PAGE_LSB+1] == addr[ADDR_W-1:PAGE_LSB+1]
          && eeSel && !flSel)
      else $error("page address moved");
   a_write_gap: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
      state == S_FETCH |-> gap < 32'(INACT_CYC))
      else $error("writes too far apart");
   a_otp_row: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
      $fell(wrStrobe_n) && inData && cmd == CMD_OTP
      |-> !busAddr[OTP_ZERO_BIT] && eeSel)
      else $error("row write address bit set");
   a_fail_recheck: assert property (@(posedge sys_clk) disable iff (rst) // [R22]
      $rose(failed) && pollCnt < 32'(POLL_LIMIT) |-> $past(recheck))
      else $error("failure declared without reread");
   a_done_after: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
      sampleNow && same |=> done ##1 state == S_IDLE)
      else $error("completion not reported");
endmodule

// ==== rtl/page_store.sv ====
// Page staging memory with registered read data
`timescale 1ns/10ps
module page_store
   #(parameter int WIDTH = 8,
     parameter int DEPTH = 64,
     parameter int IDX_W = 6)
   (input  wire logic             sys_clk,
    input  wire logic             wrEn,
    input  wire logic [IDX_W-1:0] wrIdx,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [IDX_W-1:0] rdIdx,
    output logic      [WIDTH-1:0] rdData);

   logic [WIDTH-1:0] mem [DEPTH];

   initial begin
      if (DEPTH > (1 << IDX_W) || WIDTH < 1)
         $error("page_store: DEPTH does not fit IDX_W");
   end

   always_ff @(posedge sys_clk) begin
      if (wrEn)
         mem[wrIdx] <= wrData;
   end

   always_ff @(posedge sys_clk) begin
      rdData <= mem[rdIdx];
   end
endmodule
